// file: twi_pkg.sv
// Purpose: shared constants and types for the two-wire bus framing block
// Assumes: 10 MHz system clock, bus clock up to 400 kHz
// Notes:   counts derive from ns times and clock period
package twi_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;          // system clock period
    localparam int unsigned MAX_BUS_HZ     = 400_000;      // fastest bus clock
    localparam int unsigned HALF_BIT_NS    = 1_250;        // half period at top rate
    // half-bit count, rounded up
    localparam int unsigned HALF_BIT_CYC   = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADDR_BITS      = 7;            // slave address width
    localparam int unsigned BYTE_BITS      = 8;            // bits per byte
    localparam logic [3:0]  LAST_BIT_IDX   = 4'h8;         // ninth clock = acknowledge
    localparam logic [6:0]  GEN_CALL_ADDR  = 7'h00;        // general call address
    localparam logic [3:0]  RSVD_ADDR_HI   = 4'hf;         // reserved upper nibble
    localparam logic        DIR_READ       = 1'b1;         // direction bit: read
    localparam logic        ACK_LEVEL      = 1'b0;         // low line = acknowledge

    // master sequencer states
    typedef enum logic [3:0] {
        TWI_IDLE    = 4'b0000,
        TWI_START_A = 4'b0001,
        TWI_START_B = 4'b0010,
        TWI_LOW     = 4'b0011,
        TWI_HIGH    = 4'b0100,
        TWI_STOP_A  = 4'b0101,
        TWI_STOP_B  = 4'b0110,
        TWI_STOP_C  = 4'b0111,
        TWI_RS_A    = 4'b1000
    } twi_state_t;

    // address legal for this master
    function automatic logic twi_addr_ok(input logic [6:0] addr, input logic rd);
        twi_addr_ok = (addr[6:3] != RSVD_ADDR_HI) && !((addr == GEN_CALL_ADDR) && (rd == DIR_READ));
    endfunction : twi_addr_ok
endpackage : twi_pkg

// file: twi_sync.sv
// Purpose: two-flop synchroniser for the bus pin levels
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module twi_sync #(
    parameter int unsigned W = 2                    // number of lines
) (
    input  wire logic         sys_clk,              // system clock
    input  wire logic         rst,                  // async reset, high
    input  wire logic [W-1:0] d,                    // raw pin levels
    output logic      [W-1:0] q                     // synchronised levels
);
    logic [W-1:0] meta;                             // first stage

    // released bus idles high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : twi_sync
`default_nettype wire

// file: twi_cond_det.sv
// Purpose: start/stop detection, clock edge detection and bus-busy tracking
// Assumes: synchronised clock and data levels
// Notes:   one cycle pulses out
`timescale 1ns/10ps
`default_nettype none
module twi_cond_det (
    input  wire logic sys_clk,                      // system clock
    input  wire logic rst,                          // async reset, high
    input  wire logic scl,                          // synced clock line
    input  wire logic sda,                          // synced data line
    output logic      start_det,                    // start or repeated start seen
    output logic      stop_det,                     // stop seen
    output logic      rise_det,                     // clock line rose
    output logic      fall_det,                     // clock line fell
    output logic      busy                          // bus between start and stop
);
    logic scl_d;                                    // previous clock level
    logic sda_d;                                    // previous data level

    // previous levels
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // edge and condition pulses
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            start_det <= 1'b0;
            stop_det  <= 1'b0;
            rise_det  <= 1'b0;
            fall_det  <= 1'b0;
        end else begin
            start_det <= scl && scl_d && sda_d && !sda;
            stop_det  <= scl && scl_d && !sda_d && sda;
            rise_det  <= scl && !scl_d;
            fall_det  <= !scl && scl_d;
        end
    end

    // busy from start until stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
        end else if (stop_det) begin
            busy <= 1'b0;
        end
    end
endmodule : twi_cond_det
`default_nettype wire

// file: twi_framing.sv
// Purpose: master and slave framing engine for the two-wire bus
// Assumes: open-drain pins resolved outside; 10 MHz sys_clk
// Notes:   one byte per request; user sequences address, data and stop
//
// Behaviour
// - one clock pulse per bit, data stable high
// - start: data falls; stop: data rises, clock high
// - bus busy between start and stop
// - repeated start keeps the bus busy
// - address packet: seven bits, direction, acknowledge
// - direction one reads, zero writes
// - after address nack, stop or repeated start
// - all-zero address is general call
// - enabled slaves acknowledge general call write
// - never send general call with read
// - addresses 1111xxx are reserved
// - data packet: eight bits msb first, ack
// - low ninth bit acknowledges, high does not
// - receiver nacks its final byte
// - master makes clock, start and stop
// - no start directly followed by stop
// - master waits while slave holds clock low
// - master alone sets clock-high time
// - lines only pulled low or released
// - bus clock at most 400 kHz
`timescale 1ns/10ps
`default_nettype none
module twi_framing #(
    parameter int unsigned HALF_CYC = twi_pkg::HALF_BIT_CYC   // clock half period
) (
    input  wire logic       sys_clk,                // system clock
    input  wire logic       rst,                    // async reset, high
    // bus pins, open drain
    input  wire logic       scl_in,                 // clock line level
    output logic            scl_out,                // clock drive value, always 0
    output logic            scl_oe,                 // pull clock low
    input  wire logic       sda_in,                 // data line level
    output logic            sda_out,                // data drive value, always 0
    output logic            sda_oe,                 // pull data low
    // master request
    input  wire logic       m_req,                  // request pulse
    input  wire logic       m_start,                // send start or repeated start only
    input  wire logic       m_addr,                 // byte is address packet
    input  wire logic       m_stop,                 // send stop only
    input  wire logic [7:0] m_wdata,                // byte to send or 0xff to read
    input  wire logic       m_ack_out,              // ack level when reading
    output logic            m_done,                 // request finished pulse
    output logic            m_rdata_ack,            // ack seen (low line)
    output logic [7:0]      m_rdata,                // byte read back
    output logic            m_err,                  // request refused pulse
    output logic            m_active,               // sequencer busy
    // slave side
    input  wire logic [6:0] own_addr,               // own slave address
    input  wire logic       gc_en,                  // accept general call
    input  wire logic       s_ack_en,               // acknowledge own traffic
    input  wire logic [7:0] s_tx_data,              // byte to return on read
    output logic            s_rx_valid,             // received data byte pulse
    output logic [7:0]      s_rx_data,              // received byte
    output logic            s_addressed,            // selected since last start
    output logic            s_read,                 // last address had read direction
    output logic            s_gcall,                // general call address seen
    output logic            bus_busy,               // start seen, no stop yet
    output logic            start_seen,             // start pulse
    output logic            stop_seen               // stop pulse
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

    logic [1:0]  sync_q;                            // synced scl, sda
    logic        scl_s;                             // synced clock
    logic        sda_s;                             // synced data
    logic        start_p, stop_p, rise_p, fall_p;   // detector pulses
    logic        busy_q;                            // detector busy
    twi_pkg::twi_state_t state;                     // master state
    logic [CW-1:0] tmr;                             // half-bit timer
    logic [3:0]  mbit;                              // master bit index
    logic [8:0]  mshift;                            // master shift, ack last
    logic        sent_addr;                         // address since start
    logic        sent_data;                         // data since start
    logic        m_scl_low, m_sda_low;              // master pull requests
    logic [3:0]  sbit;                              // slave bit index
    logic [7:0]  sshift;                            // slave receive shift
    logic        s_in_addr;                         // slave in address packet
    logic        s_sel;                             // slave selected
    logic        s_rd;                              // last address had read direction
    logic        s_sda_low;                         // slave pull request
    logic [7:0]  s_txsh;                            // slave transmit shift
    logic        tmr_done;                          // timer expired

    assign scl_s    = sync_q[1];
    assign sda_s    = sync_q[0];
    assign tmr_done = (tmr == HALF_LAST);

    // pin synchroniser
    twi_sync #(.W(2)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({scl_in, sda_in}),
        .q       (sync_q)
    );

    // start, stop, edges and busy
    twi_cond_det u_det (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .scl       (scl_s),
        .sda       (sda_s),
        .start_det (start_p),
        .stop_det  (stop_p),
        .rise_det  (rise_p),
        .fall_det  (fall_p),
        .busy      (busy_q)
    );

    // half-bit timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmr <= '0;
        end else if (state == twi_pkg::TWI_IDLE || tmr_done) begin
            tmr <= '0;
        end else if (state == twi_pkg::TWI_HIGH && !scl_s) begin
            tmr <= '0;                              // wait for release
        end else begin
            tmr <= tmr + CW'(1);
        end
    end

    // master sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state     <= twi_pkg::TWI_IDLE;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            mbit      <= '0;
            mshift    <= '1;
            sent_addr <= 1'b0;
            sent_data <= 1'b0;
            m_done    <= 1'b0;
            m_err     <= 1'b0;
            m_rdata   <= '0;
            m_rdata_ack <= 1'b0;
        end else begin
            m_done <= 1'b0;
            m_err  <= 1'b0;
            unique case (state)
                twi_pkg::TWI_IDLE: begin
                    if (m_req) begin
                        mbit   <= '0;
                        mshift <= {m_wdata, m_ack_out};
                        if (m_stop) begin
                            if (m_scl_low && sent_addr) begin
                                state <= twi_pkg::TWI_STOP_A;
                            end else begin
                                m_err <= 1'b1;                      // no empty frame
                            end
                        end else if (m_start) begin
                            if (busy_q && !m_scl_low) begin
                                m_err <= 1'b1;
                            end else if (m_scl_low) begin
                                state <= twi_pkg::TWI_RS_A;
                            end else begin
                                state <= twi_pkg::TWI_START_A;
                            end
                        end else if (!m_scl_low) begin
                            m_err <= 1'b1;                          // no bus owned
                        end else if (m_addr &&
                                     !twi_pkg::twi_addr_ok(m_wdata[7:1], m_wdata[0])) begin
                            m_err <= 1'b1;
                        end else begin
                            sent_addr <= sent_addr | m_addr;
                            sent_data <= sent_data | !m_addr;
                            state     <= twi_pkg::TWI_LOW;
                        end
                    end
                end
                twi_pkg::TWI_RS_A: begin
                    m_sda_low <= 1'b0;              // release data, then clock
                    if (tmr_done) begin
                        m_scl_low <= 1'b0;
                        state     <= twi_pkg::TWI_START_A;
                    end
                end
                twi_pkg::TWI_START_A: begin
                    if (tmr_done && scl_s && sda_s) begin
                        m_sda_low <= 1'b1;          // data falls, clock high
                        state     <= twi_pkg::TWI_START_B;
                    end
                end
                twi_pkg::TWI_START_B: begin
                    if (tmr_done) begin
                        m_scl_low <= 1'b1;
                        sent_addr <= 1'b0;
                        sent_data <= 1'b0;
                        m_done    <= 1'b1;
                        state     <= twi_pkg::TWI_IDLE;
                    end
                end
                twi_pkg::TWI_LOW: begin
                    m_sda_low <= !mshift[8];        // change only while low
                    if (tmr_done) begin
                        m_scl_low <= 1'b0;
                        state     <= twi_pkg::TWI_HIGH;
                    end
                end
                twi_pkg::TWI_HIGH: begin
                    if (tmr_done) begin             // high time counted here
                        m_scl_low <= 1'b1;
                        mshift    <= {mshift[7:0], sda_s};
                        if (mbit == twi_pkg::LAST_BIT_IDX) begin
                            m_rdata     <= mshift[7:0];
                            m_rdata_ack <= (sda_s == twi_pkg::ACK_LEVEL);
                            m_done      <= 1'b1;
                            state       <= twi_pkg::TWI_IDLE;
                        end else begin
                            mbit  <= mbit + 4'h1;
                            state <= twi_pkg::TWI_LOW;
                        end
                    end
                end
                twi_pkg::TWI_STOP_A: begin
                    m_sda_low <= 1'b1;              // data low under low clock
                    if (tmr_done) begin
                        m_scl_low <= 1'b0;
                        state     <= twi_pkg::TWI_STOP_B;
                    end
                end
                twi_pkg::TWI_STOP_B: begin
                    if (tmr_done && scl_s) begin
                        m_sda_low <= 1'b0;          // data rises, clock high
                        state     <= twi_pkg::TWI_STOP_C;
                    end
                end
                twi_pkg::TWI_STOP_C: begin
                    if (tmr_done) begin
                        m_done <= 1'b1;
                        state  <= twi_pkg::TWI_IDLE;
                    end
                end
                default: state <= twi_pkg::TWI_IDLE;
            endcase
        end
    end

    // slave receive path
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sbit       <= '0;
            sshift     <= '0;
            s_in_addr  <= 1'b0;
            s_sel      <= 1'b0;
            s_rd       <= 1'b0;
            s_gcall    <= 1'b0;
            s_rx_valid <= 1'b0;
            s_rx_data  <= '0;
        end else begin
            s_rx_valid <= 1'b0;
            if (start_p) begin
                sbit      <= '0;                    // treated like start
                s_in_addr <= 1'b1;
                s_sel     <= 1'b0;
                s_gcall   <= 1'b0;
                s_rd      <= 1'b0;
            end else if (stop_p) begin
                s_in_addr <= 1'b0;
                s_sel     <= 1'b0;
                s_gcall   <= 1'b0;
            end else if (rise_p && busy_q) begin
                if (sbit == twi_pkg::LAST_BIT_IDX) begin
                    sbit      <= '0;
                    s_in_addr <= 1'b0;
                end else begin
                    sbit   <= sbit + 4'h1;
                    sshift <= {sshift[6:0], sda_s};
                end
                if (sbit == 4'(twi_pkg::BYTE_BITS - 1)) begin
                    if (s_in_addr) begin
                        s_rd    <= (sda_s == twi_pkg::DIR_READ);
                        s_sel   <= s_ack_en && ((sshift[6:0] == own_addr) ||
                                   (gc_en && sshift[6:0] == twi_pkg::GEN_CALL_ADDR &&
                                    sda_s != twi_pkg::DIR_READ));
                        s_gcall <= (sshift[6:0] == twi_pkg::GEN_CALL_ADDR);
                    end else if (s_sel && !s_rd) begin
                        s_rx_valid <= 1'b1;
                        s_rx_data  <= {sshift[6:0], sda_s};
                    end
                end
            end
        end
    end

    // slave data drive, changed on clock fall, released on start or stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_sda_low <= 1'b0;
            s_txsh    <= '1;
        end else if (start_p || stop_p) begin
            s_sda_low <= 1'b0;
        end else if (fall_p) begin
            if (sbit == twi_pkg::LAST_BIT_IDX) begin
                s_sda_low <= s_sel && (s_in_addr || !s_rd) && s_ack_en;
                s_txsh    <= s_tx_data;
            end else if (s_sel && s_rd && !s_in_addr) begin
                s_sda_low <= !s_txsh[7];
                s_txsh    <= {s_txsh[6:0], 1'b1};
            end else begin
                s_sda_low <= 1'b0;
            end
        end
    end

    // registered pin drives and status
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_oe      <= 1'b0;
            sda_oe      <= 1'b0;
            scl_out     <= 1'b0;
            sda_out     <= 1'b0;
            m_active    <= 1'b0;
            bus_busy    <= 1'b0;
            start_seen  <= 1'b0;
            stop_seen   <= 1'b0;
            s_addressed <= 1'b0;
            s_read      <= 1'b0;
        end else begin
            scl_oe      <= m_scl_low;
            sda_oe      <= m_sda_low || s_sda_low;
            m_active    <= (state != twi_pkg::TWI_IDLE);
            bus_busy    <= busy_q;
            start_seen  <= start_p;
            stop_seen   <= stop_p;
            s_addressed <= s_sel;
            s_read      <= s_rd;
        end
    end
endmodule : twi_framing
`default_nettype wire

// file: twi_framing_sva.sv
// Purpose: port-level checks on the framing engine
// Assumes: single sys_clk domain, rst async high
// Notes:   bound into every twi_framing instance
`timescale 1ns/10ps
`default_nettype none
module twi_framing_sva #(
    parameter int unsigned HALF_CYC = 13           // clock half period
) (
    input wire logic       sys_clk,                // system clock
    input wire logic       rst,                    // async reset
    input wire logic       scl_in,                 // clock line level
    input wire logic       scl_out,                // clock drive value
    input wire logic       scl_oe,                 // clock pull low
    input wire logic       sda_out,                // data drive value
    input wire logic       sda_oe,                 // data pull low
    input wire logic       m_req,                  // request pulse
    input wire logic       m_start,                // start request
    input wire logic       m_addr,                 // address byte
    input wire logic       m_stop,                 // stop request
    input wire logic [7:0] m_wdata,                // byte to send
    input wire logic       m_err,                  // refused pulse
    input wire logic       m_active,               // sequencer busy
    input wire logic       s_addressed,            // slave selected
    input wire logic       bus_busy,               // bus busy level
    input wire logic       start_seen,             // start pulse
    input wire logic       stop_seen               // stop pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // an address byte request taken while idle
    wire byte_req = m_req && !m_active && !m_stop && !m_start && m_addr;
    a_drive_only_low: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_stop_idle_err: assert property (m_req && !m_active && m_stop && !bus_busy
        |-> ##[1:2] m_err) else $error("idle stop taken");
    a_rsvd_addr_err: assert property (byte_req && m_wdata[7:4] == 4'hf
        |-> ##[1:2] m_err) else $error("reserved addr sent");
    a_gc_read_err: assert property (byte_req && m_wdata == 8'h01
        |-> ##[1:2] m_err) else $error("gc read sent");
    a_start_busy: assert property (start_seen |-> ##[0:1] bus_busy)
        else $error("no busy after start");
    a_stop_free: assert property (stop_seen |-> ##[0:1] !bus_busy)
        else $error("busy kept after stop");
    a_rstart_busy: assert property (start_seen && bus_busy |=> bus_busy)
        else $error("rstart freed bus");
    a_clk_high_min: assert property ($fell(scl_oe) |=> !scl_oe [*3])
        else $error("clock high too short");
    a_clk_low_min: assert property ($rose(scl_oe) |=> scl_oe [*3])
        else $error("clock low too short");
    a_slave_sda_low: assert property ($changed(sda_oe) && s_addressed && !m_active
        |-> !scl_in) else $error("data moved, clock high");
    c_start: cover property (start_seen);
    c_stop: cover property (stop_seen);
    c_refuse: cover property (m_err);
endmodule : twi_framing_sva
bind twi_framing twi_framing_sva #(.HALF_CYC(HALF_CYC)) i_twi_framing_sva (.*);
`default_nettype wire

// file: twi_bus_slave.sv
// Purpose: behavioural slave on the far side of the bus
// Assumes: resolved open-drain lines as inputs
// Notes:   acks own address, returns a fixed byte on read
`timescale 1ns/10ps
`default_nettype none
module twi_bus_slave #(
    parameter logic [6:0] ADDR = 7'h2a,            // own address
    parameter logic [7:0] TXB  = 8'ha5             // byte returned on read
) (
    input  wire logic scl,                         // clock line
    input  wire logic sda,                         // data line
    input  wire logic stretch,                     // hold clock low after falls
    output logic      scl_oe,                      // pull clock low
    output logic      sda_oe                       // pull data low
);
    logic [7:0] rx;                                // shift register
    logic       sel, rd, first, nak;               // selection state
    int         n = -2;                            // bits done, -2 idle
    initial begin scl_oe = 0; sda_oe = 0; sel = 0; end
    // start and stop detection, clock high
    always @(negedge sda) if (scl) begin n = -1; first = 1; sel = 0; end
    always @(posedge sda) if (scl) begin n = -2; sel = 0; end
    // sample at clock rise
    always @(posedge scl) if (n >= 0 && n < 8) rx = {rx[6:0], sda};
    always @(posedge scl) if (n == 8) nak = sda;
    // drive ack or read bits after each fall
    always @(negedge scl) if (n >= -1) begin
        n = n + 1;
        if (n == 8) sda_oe = first ? (rx[7:1] == ADDR) : (sel && !rd);
        else if (n == 9) begin
            if (first) begin sel = (rx[7:1] == ADDR); rd = rx[0]; nak = 0; end
            first = 0;
            n = 0;
            sda_oe = sel && rd && !nak && !TXB[7];
        end else if (n > 0) sda_oe = sel && rd && !nak && !TXB[7 - n];
    end
    // optional stretch of the low phase
    always @(negedge scl) if (stretch) begin scl_oe = 1; #2000; scl_oe = 0; end
endmodule : twi_bus_slave
`default_nettype wire

// file: two_wire_bus_framing_tb.sv
// Purpose: self-checking bench for the framing engine as master
// Assumes: HALF_CYC 4, giving an 1100 ns bus clock period without stretch
// Notes:   far slave is twi_bus_slave at address 2a
`timescale 1ns/10ps
`default_nettype none
module two_wire_bus_framing_tb;
    logic sys_clk, rst, m_req, m_start, m_addr, m_stop, m_ack_out, stretch, e;
    logic [7:0] m_wdata, m_rdata; // request and read byte
    logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, m_done, m_err, m_rdata_ack, bus_busy;
    int failures = 0, n_tests = 0; // counters
    wire scl = !(scl_oe | s_scl_oe); // wired-and clock
    wire sda = !(sda_oe | s_sda_oe); // wired-and data
    twi_framing #(.HALF_CYC(4)) i_twi_framing (.sys_clk(sys_clk), .rst(rst),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .m_req(m_req), .m_start(m_start), .m_addr(m_addr),
        .m_stop(m_stop), .m_wdata(m_wdata), .m_ack_out(m_ack_out), .m_done(m_done),
        .m_rdata_ack(m_rdata_ack), .m_rdata(m_rdata), .m_err(m_err), .m_active(),
        .own_addr(7'h33), .gc_en(1'b1), .s_ack_en(1'b1), .s_tx_data(8'h00),
        .s_rx_valid(), .s_rx_data(), .s_addressed(), .s_read(), .s_gcall(),
        .bus_busy(bus_busy), .start_seen(), .stop_seen());
    twi_bus_slave i_twi_bus_slave (.scl(scl), .sda(sda), .stretch(stretch),
        .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
    initial begin sys_clk = 0; forever #50 sys_clk = ~sys_clk; end
    // compare and count
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, x, g); end
    endtask : chk
    // one request, wait for done or refusal
    task automatic op(input logic st, sp, ad, input logic [7:0] wd, input logic ao);
        int k;
        @(negedge sys_clk);
        {m_start, m_stop, m_addr, m_wdata, m_ack_out, m_req} = {st, sp, ad, wd, ao, 1'b1};
        @(negedge sys_clk);
        m_req = 0;
        for (k = 0; k < 3000 && m_done !== 1'b1 && m_err !== 1'b1; k++) @(negedge sys_clk);
        if (k == 3000) failures++;
        e = m_err;
    endtask : op
    task automatic t_refuse;
        op(0, 1, 0, 8'h00, 1); chk("stop idle", 1, e);
        op(0, 0, 0, 8'h55, 1); chk("byte idle", 1, e);
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_write;
        stretch = 1;
        op(1, 0, 0, 8'h00, 1); repeat (3) @(negedge sys_clk);
        chk("busy", 1, bus_busy);
        op(0, 0, 1, 8'h54, 1); chk("addr ack", 1, m_rdata_ack);
        op(0, 0, 0, 8'h3c, 1); chk("data ack", 1, m_rdata_ack);
        chk("rx byte", 8'h3c, i_twi_bus_slave.rx);
        stretch = 0;
        op(0, 1, 0, 8'h00, 1); repeat (4) @(negedge sys_clk);
        chk("free", 0, bus_busy);
        $display("write test done");
    endtask : t_write
    task automatic t_read;
        op(1, 0, 0, 8'h00, 1);
        op(0, 0, 1, 8'h2a, 1); chk("nack", 0, m_rdata_ack);
        op(1, 0, 0, 8'h00, 1); chk("rstart", 0, e);
        op(0, 0, 1, 8'hf0, 1); chk("rsvd", 1, e);
        op(0, 0, 1, 8'h01, 1); chk("gc read", 1, e);
        op(0, 0, 1, 8'h55, 1); chk("rd ack", 1, m_rdata_ack);
        op(0, 0, 0, 8'hff, 1); chk("rd byte", 8'ha5, m_rdata);
        op(0, 1, 0, 8'h00, 1); chk("stop", 0, e);
        $display("read test done");
    endtask : t_read
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        {rst, m_req, m_start, m_addr, m_stop, m_wdata, m_ack_out, stretch} = 0;
        rst = 1;
        repeat (4) @(negedge sys_clk);
        rst = 0;
        t_refuse();
        t_write();
        t_read();
        wrap_up();
    end
    initial begin #2000000; failures++; wrap_up(); end
endmodule : two_wire_bus_framing_tb
`default_nettype wire
